// file: panel_status_defines.svh
// Functional notes
// - Mask bit one suppresses its warning
// - Mask bit 2 gates life-expectancy warning
// - Mask bit 5 gates excessive-regeneration warning
// - Mask bit 6 gates fan warning
// - Mask bit 7 gates overload warning
// - Bits 8-10 gate encoder and vibration warnings
// - Select 0 shows blank off, 00 on
// - Select 2 shows electrical angle in hex
// - Select 3 shows saturating fieldbus error low byte
// - Select 6 shows saturating encoder error low byte
// - Select 4 shows power-on node address decimal
// - Select 7 shows raw Z-phase count with incremental encoder, else blank
// - Error counters clear only at power-off
// - Select register signed, 0 to 32767, default 0
// - Address shown for setting times 100 ms
// - Force flag setting 0 to 1, default 1
// - Setting 0 includes command, 1 excludes it
`ifndef PANEL_STATUS_DEFINES_SVH
`define PANEL_STATUS_DEFINES_SVH

`define AXI_AW          18
`define IDX_SEL         16'h3700
`define IDX_DUR         16'h3701
`define IDX_FLC         16'h3703
`define IDX_MASK        16'h3638
`define IDX_STAT        16'h3710
`define SEL_RESET       16'h0000
`define DUR_RESET       16'h0000
`define FLC_RESET       16'h0001
`define MASK_RESET      16'h0004
`define DUR_MAX         16'h03E8
`define FLC_MAX         16'h0001
`define WARN_IMPL_MASK  16'h07E4
`define WARN_LIFE_BIT   2
`define WARN_REGEN_BIT  5
`define WARN_FAN_BIT    6
`define WARN_OVLD_BIT   7
`define WARN_EXTE_BIT   8
`define WARN_VIB_BIT    9
`define WARN_EXTC_BIT   10
`define DSEL_STATE      16'h0000
`define DSEL_ANGLE      16'h0002
`define DSEL_FBERR      16'h0003
`define DSEL_NODE       16'h0004
`define DSEL_ENCERR     16'h0006
`define DSEL_ZPHASE     16'h0007
`define CNT_MAX         16'hFFFF
`define SEG_BLANK       7'h00
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define ADDR_UNIT_MS    100
`define CORE_CLK_MHZ    100
`define UNIT_CYCLES     (`ADDR_UNIT_MS * 1000 * `CORE_CLK_MHZ)

`endif

// file: panel_status_pkg.sv
package panel_status_pkg;

   typedef struct packed {
      logic       servo_on;
      logic       enc_incremental;
      logic [7:0] elec_angle;
      logic [7:0] zphase_count;
   } drive_in_t;

   typedef enum logic [1:0] {
      MODE_BLANK = 2'b00,
      MODE_HEX   = 2'b01,
      MODE_DEC   = 2'b10
   } disp_mode_t;

   typedef enum logic [1:0] {
      PH_ADDR   = 2'b01,
      PH_SELECT = 2'b10
   } phase_t;

   typedef enum logic [2:0] {
      RS_NONE,
      RS_SEL,
      RS_DUR,
      RS_FLC,
      RS_MASK,
      RS_STAT
   } reg_sel_t;

endpackage : panel_status_pkg

// file: seg_pair_encoder.sv
`timescale 1ns/1ns
`include "panel_status_defines.svh"
module seg_pair_encoder (
   input  wire logic [7:0]                    i_value,
   input  wire panel_status_pkg::disp_mode_t  i_mode,
   output logic      [6:0]                    o_seg_tens,
   output logic      [6:0]                    o_seg_ones
);
   import panel_status_pkg::*;

   // Segments gfedcba, active high
   function automatic logic [6:0] digit_seg(input logic [3:0] d);
      case (d)
         4'h0: digit_seg = 7'h3F;
         4'h1: digit_seg = 7'h06;
         4'h2: digit_seg = 7'h5B;
         4'h3: digit_seg = 7'h4F;
         4'h4: digit_seg = 7'h66;
         4'h5: digit_seg = 7'h6D;
         4'h6: digit_seg = 7'h7D;
         4'h7: digit_seg = 7'h07;
         4'h8: digit_seg = 7'h7F;
         4'h9: digit_seg = 7'h6F;
         4'hA: digit_seg = 7'h77;
         4'hB: digit_seg = 7'h7C;
         4'hC: digit_seg = 7'h39;
         4'hD: digit_seg = 7'h5E;
         4'hE: digit_seg = 7'h79;
         default: digit_seg = 7'h71;
      endcase
   endfunction : digit_seg

   logic [7:0] dec_val;

   always_comb begin
      // Two digits only: hundreds are dropped
      dec_val = i_value % 8'd100;
      case (i_mode)
         MODE_HEX: begin
            o_seg_tens = digit_seg(i_value[7:4]);
            o_seg_ones = digit_seg(i_value[3:0]);
         end
         MODE_DEC: begin
            o_seg_tens = digit_seg(4'(dec_val / 8'd10));
            o_seg_ones = digit_seg(4'(dec_val % 8'd10));
         end
         default: begin
            o_seg_tens = `SEG_BLANK;
            o_seg_ones = `SEG_BLANK;
         end
      endcase
   end

endmodule : seg_pair_encoder

// file: panel_status_ctrl.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "panel_status_defines.svh"
module panel_status_ctrl #(
   parameter int unsigned P_UNIT_CYCLES = `UNIT_CYCLES
) (
   input  wire logic                         i_core_clk,
   input  wire logic                         i_srst,
   input  wire logic                         i_awvalid,
   output logic                              o_awready,
   input  wire logic [`AXI_AW-1:0]           i_awaddr,
   input  wire logic [2:0]                   i_awprot,
   input  wire logic                         i_wvalid,
   output logic                              o_wready,
   input  wire logic [31:0]                  i_wdata,
   input  wire logic [3:0]                   i_wstrb,
   output logic                              o_bvalid,
   input  wire logic                         i_bready,
   output logic      [1:0]                   o_bresp,
   input  wire logic                         i_arvalid,
   output logic                              o_arready,
   input  wire logic [`AXI_AW-1:0]           i_araddr,
   input  wire logic [2:0]                   i_arprot,
   output logic                              o_rvalid,
   input  wire logic                         i_rready,
   output logic      [31:0]                  o_rdata,
   output logic      [1:0]                   o_rresp,
   input  wire panel_status_pkg::drive_in_t  i_drive,
   input  wire logic [15:0]                  i_warn_raw,
   input  wire logic                         i_fieldbus_err,
   input  wire logic                         i_ext_enc_err,
   input  wire logic [7:0]                   i_node_switch,
   input  wire logic                         i_limit_incl_cmd,
   input  wire logic                         i_limit_excl_cmd,
   output logic      [15:0]                  o_warn_active,
   output logic                              o_force_limit,
   output logic      [6:0]                   o_seg_tens,
   output logic      [6:0]                   o_seg_ones
);
   import panel_status_pkg::*;

   localparam int TW = (P_UNIT_CYCLES > 1) ? $clog2(P_UNIT_CYCLES) : 1;

   function automatic reg_sel_t decode(input logic [`AXI_AW-1:0] a);
      decode = RS_NONE;
      if (a[1:0] == 2'b00) begin
         case (a[`AXI_AW-1:2])
            `IDX_SEL:  decode = RS_SEL;
            `IDX_DUR:  decode = RS_DUR;
            `IDX_FLC:  decode = RS_FLC;
            `IDX_MASK: decode = RS_MASK;
            `IDX_STAT: decode = RS_STAT;
            default:   decode = RS_NONE;
         endcase
      end
   endfunction : decode

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      merge = old;
      if (s[0]) merge[7:0] = d[7:0];
      if (s[1]) merge[15:8] = d[15:8];
   endfunction : merge

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == `CNT_MAX) ? v : v + 16'h0001;
   endfunction : sat_inc

   // Bus slave state
   logic                 aw_got_reg,  aw_got_next;
   logic [`AXI_AW-1:0]   awaddr_reg,  awaddr_next;
   logic                 w_got_reg,   w_got_next;
   logic [31:0]          wdata_reg,   wdata_next;
   logic [3:0]           wstrb_reg,   wstrb_next;
   logic                 bvalid_reg,  bvalid_next;
   logic [1:0]           bresp_reg,   bresp_next;
   logic                 rvalid_reg,  rvalid_next;
   logic [31:0]          rdata_reg,   rdata_next;
   logic [1:0]           rresp_reg,   rresp_next;
   // Settings
   logic [15:0]          sel_reg,     sel_next;
   logic [15:0]          dur_reg,     dur_next;
   logic [15:0]          flc_reg,     flc_next;
   logic [15:0]          mask_reg,    mask_next;
   // Block state
   logic [15:0]          fb_cnt_reg,  fb_cnt_next;
   logic [15:0]          enc_cnt_reg, enc_cnt_next;
   logic                 cap_reg,     cap_next;
   logic [7:0]           node_reg,    node_next;
   phase_t               phase_reg,   phase_next;
   logic [TW-1:0]        tick_reg,    tick_next;
   logic [9:0]           units_reg,   units_next;
   logic [15:0]          warn_reg,    warn_next;
   logic                 flag_reg,    flag_next;
   logic [6:0]           tens_reg,    tens_next;
   logic [6:0]           ones_reg,    ones_next;
   disp_mode_t           disp_mode;
   logic [7:0]           disp_val;
   logic [6:0]           enc_tens;
   logic [6:0]           enc_ones;
   logic                 do_write;
   logic [15:0]          wval;
   reg_sel_t             wsel;

   assign o_awready = !aw_got_reg;
   assign o_wready  = !w_got_reg;
   assign o_arready = !rvalid_reg;
   assign o_bvalid  = bvalid_reg;
   assign o_bresp   = bresp_reg;
   assign o_rvalid  = rvalid_reg;
   assign o_rdata   = rdata_reg;
   assign o_rresp   = rresp_reg;
   assign do_write  = aw_got_reg && w_got_reg && !bvalid_reg;

   always_comb begin
      aw_got_next = aw_got_reg;
      awaddr_next = awaddr_reg;
      w_got_next  = w_got_reg;
      wdata_next  = wdata_reg;
      wstrb_next  = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next  = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      sel_next    = sel_reg;
      dur_next    = dur_reg;
      flc_next    = flc_reg;
      mask_next   = mask_reg;
      wsel        = decode(awaddr_reg);
      wval        = 16'h0000;
      if (i_awvalid && !aw_got_reg) begin
         aw_got_next = 1'b1;
         awaddr_next = i_awaddr;
      end
      if (i_wvalid && !w_got_reg) begin
         w_got_next = 1'b1;
         wdata_next = i_wdata;
         wstrb_next = i_wstrb;
      end
      if (bvalid_reg && i_bready) begin
         bvalid_next = 1'b0;
      end
      if (do_write) begin
         aw_got_next = 1'b0;
         w_got_next  = 1'b0;
         bvalid_next = 1'b1;
         bresp_next  = `RESP_OKAY;
         // Out-of-range values are refused and the old value kept
         case (wsel)
            RS_SEL: begin
               wval = merge(sel_reg, wdata_reg, wstrb_reg);
               if (!wval[15]) sel_next = wval;
               else bresp_next = `RESP_SLVERR;
            end
            RS_DUR: begin
               wval = merge(dur_reg, wdata_reg, wstrb_reg);
               if (wval <= `DUR_MAX) dur_next = wval;
               else bresp_next = `RESP_SLVERR;
            end
            RS_FLC: begin
               wval = merge(flc_reg, wdata_reg, wstrb_reg);
               if (wval <= `FLC_MAX) flc_next = wval;
               else bresp_next = `RESP_SLVERR;
            end
            RS_MASK: begin
               mask_next = merge(mask_reg, wdata_reg, wstrb_reg);
            end
            default: begin
               bresp_next = `RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_reg && i_rready) begin
         rvalid_next = 1'b0;
      end
      if (i_arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = `RESP_OKAY;
         case (decode(i_araddr))
            RS_SEL:  rdata_next = {16'h0000, sel_reg};
            RS_DUR:  rdata_next = {16'h0000, dur_reg};
            RS_FLC:  rdata_next = {16'h0000, flc_reg};
            RS_MASK: rdata_next = {16'h0000, mask_reg};
            RS_STAT: rdata_next = {enc_cnt_reg, fb_cnt_reg};
            default: begin
               rdata_next = 32'h0000_0000;
               rresp_next = `RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         aw_got_reg <= 1'b0;
         awaddr_reg <= '0;
         w_got_reg  <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= `RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `RESP_OKAY;
         sel_reg    <= `SEL_RESET;
         dur_reg    <= `DUR_RESET;
         flc_reg    <= `FLC_RESET;
         mask_reg   <= `MASK_RESET;
      end else begin
         aw_got_reg <= aw_got_next;
         awaddr_reg <= awaddr_next;
         w_got_reg  <= w_got_next;
         wdata_reg  <= wdata_next;
         wstrb_reg  <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg  <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg  <= rdata_next;
         rresp_reg  <= rresp_next;
         sel_reg    <= sel_next;
         dur_reg    <= dur_next;
         flc_reg    <= flc_next;
         mask_reg   <= mask_next;
      end
   end

   // Drive status, power-on timer and panel
   always_comb begin
      // Reserved mask bits have no warning behind them
      warn_next    = i_warn_raw & ~mask_reg & `WARN_IMPL_MASK;
      flag_next    = (flc_reg == 16'h0000) ? i_limit_incl_cmd
                                           : i_limit_excl_cmd;
      fb_cnt_next  = i_fieldbus_err ? sat_inc(fb_cnt_reg)
                                    : fb_cnt_reg;
      enc_cnt_next = i_ext_enc_err ? sat_inc(enc_cnt_reg)
                                   : enc_cnt_reg;
      cap_next     = 1'b1;
      node_next    = cap_reg ? node_reg : i_node_switch;
      phase_next   = phase_reg;
      tick_next    = tick_reg;
      units_next   = units_reg;
      case (phase_reg)
         PH_ADDR: begin
            if ({6'h00, units_reg} >= dur_reg) begin
               phase_next = PH_SELECT;
            end else if (tick_reg == TW'(P_UNIT_CYCLES - 1)) begin
               tick_next  = '0;
               units_next = units_reg + 10'h001;
            end else begin
               tick_next = tick_reg + TW'(1);
            end
         end
         PH_SELECT: begin
            phase_next = PH_SELECT;
         end
         default: begin
            phase_next = PH_SELECT;
         end
      endcase
      disp_mode = MODE_BLANK;
      disp_val  = 8'h00;
      if (phase_reg == PH_ADDR) begin
         disp_mode = MODE_DEC;
         disp_val  = node_reg;
      end else begin
         case (sel_reg)
            `DSEL_STATE: begin
               disp_mode = i_drive.servo_on ? MODE_HEX
                                            : MODE_BLANK;
            end
            `DSEL_ANGLE: begin
               disp_mode = MODE_HEX;
               disp_val  = i_drive.elec_angle;
            end
            `DSEL_FBERR: begin
               disp_mode = MODE_HEX;
               disp_val  = fb_cnt_reg[7:0];
            end
            `DSEL_NODE: begin
               disp_mode = MODE_DEC;
               disp_val  = node_reg;
            end
            `DSEL_ENCERR: begin
               disp_mode = MODE_HEX;
               disp_val  = enc_cnt_reg[7:0];
            end
            `DSEL_ZPHASE: begin
               disp_mode = i_drive.enc_incremental ? MODE_HEX
                                                   : MODE_BLANK;
               disp_val  = i_drive.zphase_count;
            end
            default: begin
               disp_mode = MODE_BLANK;
            end
         endcase
      end
      tens_next = enc_tens;
      ones_next = enc_ones;
   end

   seg_pair_encoder u_seg (
      .i_value    (disp_val),
      .i_mode     (disp_mode),
      .o_seg_tens (enc_tens),
      .o_seg_ones (enc_ones)
   );

   // Reset stands for control power-off; only it clears the counters
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         fb_cnt_reg  <= 16'h0000;
         enc_cnt_reg <= 16'h0000;
         cap_reg     <= 1'b0;
         node_reg    <= 8'h00;
         phase_reg   <= PH_ADDR;
         tick_reg    <= '0;
         units_reg   <= 10'h000;
         warn_reg    <= 16'h0000;
         flag_reg    <= 1'b0;
         tens_reg    <= `SEG_BLANK;
         ones_reg    <= `SEG_BLANK;
      end else begin
         fb_cnt_reg  <= fb_cnt_next;
         enc_cnt_reg <= enc_cnt_next;
         cap_reg     <= cap_next;
         node_reg    <= node_next;
         phase_reg   <= phase_next;
         tick_reg    <= tick_next;
         units_reg   <= units_next;
         warn_reg    <= warn_next;
         flag_reg    <= flag_next;
         tens_reg    <= tens_next;
         ones_reg    <= ones_next;
      end
   end

   assign o_warn_active = warn_reg;
   assign o_force_limit = flag_reg;
   assign o_seg_tens    = tens_reg;
   assign o_seg_ones    = ones_reg;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   mask_gate_a: assert property (
      !i_srst |=> o_warn_active == ($past(i_warn_raw) & ~$past(mask_reg)
                            & `WARN_IMPL_MASK))
      else $error("warning output does not follow mask");
   life_bit_a: assert property (
      mask_reg[`WARN_LIFE_BIT] |=> !o_warn_active[`WARN_LIFE_BIT])
      else $error("masked life warning passed");
   regen_bit_a: assert property (
      !i_srst && !mask_reg[`WARN_REGEN_BIT] && i_warn_raw[`WARN_REGEN_BIT]
      |=> o_warn_active[`WARN_REGEN_BIT])
      else $error("unmasked regeneration warning lost");
   fan_bit_a: assert property (
      mask_reg[`WARN_FAN_BIT] |=> !o_warn_active[`WARN_FAN_BIT])
      else $error("masked fan warning passed");
   ovld_bit_a: assert property (
      !i_srst && !mask_reg[`WARN_OVLD_BIT] && i_warn_raw[`WARN_OVLD_BIT]
      |=> o_warn_active[`WARN_OVLD_BIT])
      else $error("unmasked overload warning lost");
   enc_bits_a: assert property (
      !i_srst && (i_warn_raw[10:8] & ~mask_reg[10:8]) == 3'b111
      |=> o_warn_active[10:8] == 3'b111)
      else $error("encoder or vibration warning lost");
   servo_off_a: assert property (
      phase_reg == PH_SELECT && sel_reg == `DSEL_STATE
      && !i_drive.servo_on |=> o_seg_tens == `SEG_BLANK
      && o_seg_ones == `SEG_BLANK)
      else $error("panel not blank with servo off");
   fb_sat_a: assert property (
      fb_cnt_reg == `CNT_MAX |=> fb_cnt_reg == `CNT_MAX)
      else $error("fieldbus counter left saturation");
   enc_count_a: assert property (
      i_ext_enc_err && enc_cnt_reg != `CNT_MAX
      |=> enc_cnt_reg == $past(enc_cnt_reg) + 16'h0001)
      else $error("encoder error not counted");
   node_hold_a: assert property (
      cap_reg |=> $stable(node_reg))
      else $error("node address changed after capture");
   cnt_keep_a: assert property (
      !i_fieldbus_err |=> $stable(fb_cnt_reg))
      else $error("fieldbus counter changed without error");
   sel_range_a: assert property (
      !sel_reg[15])
      else $error("display selection negative");
   flc_range_a: assert property (
      flc_reg <= `FLC_MAX)
      else $error("force flag setting out of range");
   flag_cond_a: assert property (
      flc_reg == 16'h0000 ##0 i_limit_incl_cmd |=> o_force_limit)
      else $error("flag missed limit with command");
   zero_skip_a: assert property (
      !i_srst && phase_reg == PH_ADDR && dur_reg == 16'h0000
      |=> phase_reg == PH_SELECT)
      else $error("zero duration did not skip address");

   addr_done_c: cover property (
      phase_reg == PH_ADDR ##1 phase_reg == PH_SELECT);
   write_sel_c: cover property (do_write && wsel == RS_SEL);
   fb_sat_c: cover property (fb_cnt_reg == `CNT_MAX);

endmodule : panel_status_ctrl

// file: panel_display_model.sv
`timescale 1ns/1ns
module panel_display_model (
   input  wire logic [6:0] i_seg_tens,
   input  wire logic [6:0] i_seg_ones,
   output logic      [7:0] o_shown,
   output logic            o_blank
);
   // Reads a glyph back to its hex digit; an unknown glyph reads as x
   function automatic logic [3:0] glyph(input logic [6:0] s);
      logic [6:0] lut [16];
      lut = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
              7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
      glyph = 4'hx;
      for (int k = 0; k < 16; k++) begin
         if (lut[k] === s) begin
            glyph = 4'(k);
         end
      end
   endfunction : glyph

   assign o_blank = (i_seg_tens === 7'h00) && (i_seg_ones === 7'h00);
   assign o_shown = {glyph(i_seg_tens), glyph(i_seg_ones)};
endmodule : panel_display_model

// file: tb_panel_status_ctrl.sv
`timescale 1ns/1ns
module tb_panel_status_ctrl;
   import panel_status_pkg::*;
   typedef struct packed {
      logic [15:0] sel;
      logic        on;
      logic        inc;
      logic [7:0]  val;
      logic [7:0]  exp;
      logic        blk;
   } row_t;
   logic        i_core_clk, i_srst, i_awvalid, i_wvalid, i_arvalid, blank;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic        i_fieldbus_err, i_ext_enc_err, o_force_limit;
   logic        i_limit_incl_cmd, i_limit_excl_cmd;
   logic [17:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata, rd;
   logic [1:0]  o_bresp, o_rresp, rs;
   logic [15:0] i_warn_raw, o_warn_active;
   logic [7:0]  i_node_switch, shown;
   logic [3:0]  i_wstrb;
   logic [6:0]  o_seg_tens, o_seg_ones;
   drive_in_t   i_drive;
   int          mismatches, check_count;
   int          cycles = 0;
   logic [17:0] ra [4] = '{18'h0_DC00, 18'h0_DC04, 18'h0_DC0C, 18'h0_D8E0};
   logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h1, 32'h4};
   int          wb [7] = '{2, 5, 6, 7, 8, 9, 10};
   row_t        rows [9] = '{
      '{16'h0, 0, 0, 8'h00, 8'h00, 1}, '{16'h0, 1, 0, 8'h00, 8'h00, 0},
      '{16'h2, 1, 0, 8'hA5, 8'hA5, 0}, '{16'h4, 0, 0, 8'h00, 8'h42, 0},
      '{16'h7, 0, 1, 8'h3C, 8'h3C, 0}, '{16'h7, 0, 0, 8'h3C, 8'h00, 1},
      '{16'h1, 1, 0, 8'h11, 8'h00, 1}, '{16'h5, 1, 0, 8'h11, 8'h00, 1},
      '{16'h8, 1, 0, 8'h11, 8'h00, 1}};

   panel_status_ctrl #(.P_UNIT_CYCLES(10)) panel_status_ctrl_i (
      .i_core_clk, .i_srst, .i_awvalid, .o_awready, .i_awaddr,
      .i_awprot(3'h0), .i_wvalid, .o_wready, .i_wdata, .i_wstrb,
      .o_bvalid, .i_bready(1'b1), .o_bresp, .i_arvalid, .o_arready,
      .i_araddr, .i_arprot(3'h0), .o_rvalid, .i_rready(1'b1), .o_rdata,
      .o_rresp, .i_drive, .i_warn_raw, .i_fieldbus_err, .i_ext_enc_err,
      .i_node_switch, .i_limit_incl_cmd, .i_limit_excl_cmd, .o_warn_active,
      .o_force_limit, .o_seg_tens, .o_seg_ones);
   panel_display_model panel_display_model_i (.i_seg_tens(o_seg_tens),
      .i_seg_ones(o_seg_ones), .o_shown(shown), .o_blank(blank));

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic final_report();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      {i_awaddr, i_wdata, i_awvalid, i_wvalid} <= {a, d, 2'b11};
      do begin
         @(posedge i_core_clk);
         if (o_awready && i_awvalid) i_awvalid <= 1'b0;
         if (o_wready && i_wvalid) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      rs = o_bresp;
   endtask : wr
   task automatic rdr(input logic [17:0] a);
      {i_araddr, i_arvalid} <= {a, 1'b1};
      do begin
         @(posedge i_core_clk);
         if (o_arready && i_arvalid) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      {rd, rs} = {o_rdata, o_rresp};
   endtask : rdr
   // Panel value as one word: 0x100 stands for a blank panel
   task automatic see(input logic [7:0] exp, input logic blk);
      repeat (3) @(posedge i_core_clk);
      chk(blank ? 32'h100 : 32'(shown), blk ? 32'h100 : 32'(exp));
   endtask : see

   initial begin
      i_srst = 1'b1;
      {i_awvalid, i_wvalid, i_arvalid, i_fieldbus_err, i_ext_enc_err} = '0;
      {i_awaddr, i_araddr, i_wdata, i_drive} = '0;
      i_wstrb = 4'hF;
      {i_warn_raw, i_node_switch} = {16'hFFFF, 8'h2A};
      {i_limit_incl_cmd, i_limit_excl_cmd} = 2'b10;
      repeat (6) @(posedge i_core_clk);
      i_srst <= 1'b0;
      @(posedge i_core_clk);
      i_node_switch <= 8'h07;
      see(8'h00, 1'b1);
      chk(o_force_limit, 32'h0);
      chk(o_warn_active, 32'h07E0);
      foreach (ra[k]) begin
         rdr(ra[k]);
         chk(rd, rv[k]);
      end
      foreach (wb[k]) begin
         wr(18'h0_D8E0, 32'h1 << wb[k]);
         repeat (2) @(posedge i_core_clk);
         chk(o_warn_active, 16'h07E4 & ~(16'h1 << wb[k]));
      end
      wr(18'h0_D8E0, 32'h0024);
      repeat (2) @(posedge i_core_clk);
      chk(o_warn_active, 32'h07C0);
      wr(18'h0_DC0C, 32'h0);
      repeat (2) @(posedge i_core_clk);
      chk(o_force_limit, 32'h1);
      wr(18'h0_DC0C, 32'h2);
      chk(rs, 32'h2);
      wr(18'h0_DC00, 32'h8000);
      chk(rs, 32'h2);
      wr(18'h0_DC00, 32'h7FFF);
      rdr(18'h0_DC00);
      chk(rd, 32'h7FFF);
      // Only the low byte lane is enabled, so the high byte is kept
      i_wstrb <= 4'h1;
      wr(18'h0_DC00, 32'h0000_AB05);
      i_wstrb <= 4'hF;
      rdr(18'h0_DC00);
      chk(rd, 32'h7F05);
      wr(18'h0_DC04, 32'h03E9);
      chk(rs, 32'h2);
      rdr(18'h0_DC08);
      chk(rd, 32'h0);
      chk(rs, 32'h2);
      foreach (rows[k]) begin
         wr(18'h0_DC00, 32'(rows[k].sel));
         i_drive <= {rows[k].on, rows[k].inc, rows[k].val, rows[k].val};
         see(rows[k].exp, rows[k].blk);
      end
      {i_fieldbus_err, i_ext_enc_err} <= 2'b11;
      repeat (2) @(posedge i_core_clk);
      i_ext_enc_err <= 1'b0;
      @(posedge i_core_clk);
      i_fieldbus_err <= 1'b0;
      rdr(18'h0_DC40);
      chk(rd, 32'h0002_0003);
      wr(18'h0_DC00, 32'h6);
      see(8'h02, 1'b0);
      i_fieldbus_err <= 1'b1;
      repeat (65540) @(posedge i_core_clk);
      i_fieldbus_err <= 1'b0;
      rdr(18'h0_DC40);
      chk(rd, 32'h0002_FFFF);
      wr(18'h0_DC00, 32'h3);
      see(8'hFF, 1'b0);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_srst <= 1'b0;
      @(posedge i_core_clk);
      rdr(18'h0_DC40);
      chk(rd, 32'h0);
      final_report();
   end
endmodule : tb_panel_status_ctrl
